//--- design/dlr_sink.sv
// Sink register slice: APB registers, transceiver configuration window,
// audio packet buffers and link setting mirrors.
// Assumes one clock shared with the link partner and APB master.
//
// Our own choice: register access over APB.
`include "dlr_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module dlr_sink (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  // Link from the remote source
  dlr_link_if.sink           link,
  // Transceiver configuration port, shared by every channel
  output logic               xcvr_cfg_en,
  output logic               xcvr_cfg_we,
  output logic [7:0]         xcvr_cfg_addr,
  output logic [15:0]        xcvr_cfg_wdata,
  input  wire logic          xcvr_cfg_ready,
  input  wire logic [15:0]   xcvr_cfg_rdata,
  input  wire logic          xcvr_cfg_internal_busy
);
  import dlr_pkg::*;

  localparam dlr_dev_state_t RST = '{cfg_st: DLR_CFG_IDLE, default: '0};

  dlr_dev_state_t cur;   // Registered state
  dlr_dev_state_t next_s; // Next state

  logic setup;      // APB setup cycle
  logic access;     // APB access cycle, completes now
  logic wr_acc;     // Completing write
  logic rd_acc;     // Completing read
  logic ext_kind;   // Packet belongs in the extension buffer
  logic take;       // Link word accepted

  // Address inside an inclusive word range
  function automatic logic in_range(input logic [11:0] a, input logic [11:0] lo, input logic [11:0] hi);
    in_range = (a >= lo) && (a <= hi) && (a[1:0] == 2'h0);
  endfunction

  // Address maps to a register at all
  function automatic logic mapped(input logic [11:0] a);
    unique case (a)
      `DLR_OFS_XCVR_CMD, `DLR_OFS_XCVR_RDATA, `DLR_OFS_XCVR_LOCK, `DLR_OFS_AUDIO_CTRL,
      `DLR_OFS_AUDIO_M, `DLR_OFS_AUDIO_N, `DLR_OFS_AUDIO_STAT, `DLR_OFS_LINK_RATE,
      `DLR_OFS_LANE_COUNT, `DLR_OFS_FRAMING, `DLR_OFS_TRAIN_PAT: mapped = 1'b1;
      default: mapped = in_range(a, `DLR_OFS_INFO_FIRST, `DLR_OFS_INFO_LAST) ||
                        in_range(a, `DLR_OFS_EXT_FIRST, `DLR_OFS_EXT_LAST);
    endcase
  endfunction

  // Bus phase decode; the slave answers in the first access cycle
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wr_acc = access && pwrite;
  assign rd_acc = access && !pwrite;
  assign pready = access;
  assign prdata = cur.prdata;
  assign pslverr = access && cur.pslverr;

  // Link word acceptance; with audio off every word is swallowed unseen
  assign ext_kind = (link.pkt_kind == DLR_KIND_ACM) || (link.pkt_kind == DLR_KIND_REC) ||
                    (link.pkt_kind == DLR_KIND_VSC);
  always_comb begin
    if (!cur.audio_en) begin
      link.pkt_ready = 1'b1;
    end else if (link.pkt_kind == DLR_KIND_INFO) begin
      link.pkt_ready = !cur.info_full;
    end else if (ext_kind) begin
      link.pkt_ready = !cur.ext_full;
    end else begin
      link.pkt_ready = 1'b1;
    end
  end
  assign take = link.pkt_valid && link.pkt_ready && cur.audio_en;

  // Transceiver port: one command broadcast to every channel
  assign xcvr_cfg_en    = (cur.cfg_st == DLR_CFG_ISSUE);
  assign xcvr_cfg_we    = cur.cmd[`DLR_CMD_WRITE_BIT];
  assign xcvr_cfg_addr  = cur.cmd[`DLR_CMD_ADDR_MSB:0];
  assign xcvr_cfg_wdata = cur.cmd[31:`DLR_CMD_WDATA_LSB];

  // Next-state logic for the whole slice
  always_comb begin
    next_s = cur;

    // Read data is sampled in the setup cycle so that prdata is a flop
    if (setup) begin
      next_s.pslverr = !mapped(paddr);
      next_s.prdata  = 32'h0;
      if (!pwrite) begin
        if (in_range(paddr, `DLR_OFS_INFO_FIRST, `DLR_OFS_INFO_LAST)) begin
          next_s.prdata = cur.info[cur.info_rd[2:0]];
        end else if (in_range(paddr, `DLR_OFS_EXT_FIRST, `DLR_OFS_EXT_LAST)) begin
          next_s.prdata = cur.ext[cur.ext_rd];
        end else begin
          unique case (paddr)
            `DLR_OFS_XCVR_CMD:   next_s.prdata = cur.cmd;
            `DLR_OFS_XCVR_RDATA: next_s.prdata = {16'h0, cur.cfg_rdata};
            `DLR_OFS_XCVR_LOCK:  next_s.prdata = {31'h0, xcvr_cfg_internal_busy};
            `DLR_OFS_AUDIO_CTRL: next_s.prdata = {31'h0, cur.audio_en};
            `DLR_OFS_AUDIO_M:    next_s.prdata = {8'h0, cur.m_val};
            `DLR_OFS_AUDIO_N:    next_s.prdata = {8'h0, cur.n_val};
            `DLR_OFS_AUDIO_STAT: next_s.prdata = {22'h0, cur.ext_full, 6'h0, cur.rs_cnt, cur.info_full};
            `DLR_OFS_LINK_RATE:  next_s.prdata = {24'h0, cur.rate};
            `DLR_OFS_LANE_COUNT: next_s.prdata = {27'h0, cur.lanes};
            `DLR_OFS_FRAMING:    next_s.prdata = {31'h0, cur.enh};
            `DLR_OFS_TRAIN_PAT:  next_s.prdata = {30'h0, cur.tp};
            default:             next_s.prdata = 32'h0;
          endcase
        end
      end
    end

    // Key-hole reads advance only when the access completes
    if (rd_acc && cur.info_full && in_range(paddr, `DLR_OFS_INFO_FIRST, `DLR_OFS_INFO_LAST)) begin
      if (cur.info_rd == `DLR_INFO_WORDS - 4'h1) begin
        next_s.info_rd   = 4'h0;
        next_s.info_full = 1'b0;
      end else begin
        next_s.info_rd = cur.info_rd + 4'h1;
      end
    end
    if (rd_acc && cur.ext_full && in_range(paddr, `DLR_OFS_EXT_FIRST, `DLR_OFS_EXT_LAST)) begin
      if (cur.ext_rd == `DLR_EXT_WORDS - 4'h1) begin
        next_s.ext_rd   = 4'h0;
        next_s.ext_full = 1'b0;
      end else begin
        next_s.ext_rd = cur.ext_rd + 4'h1;
      end
    end

    // Software writes; mirrors and status have no write path
    if (wr_acc) begin
      unique case (paddr)
        `DLR_OFS_XCVR_CMD:   next_s.cmd = pwdata;
        `DLR_OFS_AUDIO_CTRL: next_s.audio_en = pwdata[0];
        default: ;
      endcase
    end

    // Configuration sequencer; a command written while locked is kept but not run
    unique case (cur.cfg_st)
      DLR_CFG_IDLE: begin
        if (wr_acc && paddr == `DLR_OFS_XCVR_CMD && !xcvr_cfg_internal_busy) begin
          next_s.cfg_st = DLR_CFG_ISSUE;
        end
      end
      DLR_CFG_ISSUE: next_s.cfg_st = DLR_CFG_WAIT;
      DLR_CFG_WAIT: begin
        if (xcvr_cfg_ready) begin
          next_s.cfg_st = DLR_CFG_IDLE;
          if (!cur.cmd[`DLR_CMD_WRITE_BIT]) begin
            next_s.cfg_rdata = xcvr_cfg_rdata;
          end
        end
      end
      default: next_s.cfg_st = DLR_CFG_IDLE;
    endcase

    // Packet words from the link; a short packet still closes its buffer
    if (take) begin
      if (link.pkt_kind == DLR_KIND_INFO) begin
        next_s.info[cur.info_wr[2:0]] = link.pkt_data;
        if (link.pkt_last || cur.info_wr == `DLR_INFO_WORDS - 4'h1) begin
          next_s.info_wr   = 4'h0;
          next_s.info_full = 1'b1;
        end else begin
          next_s.info_wr = cur.info_wr + 4'h1;
        end
      end else if (ext_kind) begin
        next_s.ext[cur.ext_wr] = link.pkt_data;
        if (link.pkt_last || cur.ext_wr == `DLR_EXT_WORDS - 4'h1) begin
          next_s.ext_wr   = 4'h0;
          next_s.ext_full = 1'b1;
        end else begin
          next_s.ext_wr = cur.ext_wr + 4'h1;
        end
      end else begin
        if (cur.ts_second) begin
          next_s.n_val = link.pkt_data[23:0];
        end else begin
          next_s.m_val = link.pkt_data[23:0];
        end
        next_s.ts_second = !cur.ts_second && !link.pkt_last;
      end
    end

    // Decoder errors saturate so the debug count never wraps to zero
    if (link.rs_err && cur.audio_en && cur.rs_cnt != 2'h3) begin
      next_s.rs_cnt = cur.rs_cnt + 2'h1;
    end

    // Link setting mirrors follow the source's auxiliary writes
    if (link.aux_wr) begin
      unique case (link.aux_field)
        `DLR_AUX_RATE:    next_s.rate  = link.aux_data;
        `DLR_AUX_LANES:   next_s.lanes = link.aux_data[4:0];
        `DLR_AUX_FRAMING: next_s.enh   = link.aux_data[0];
        `DLR_AUX_TRAIN:   next_s.tp    = link.aux_data[1:0];
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= RST;
    end else begin
      cur <= next_s;
    end
  end

endmodule

`default_nettype wire

//--- design/dlr_regs.svh
// Register offsets, field positions, link codes and counts for the sink
// register slice and its link partner. Definitions only.
`ifndef DLR_REGS_SVH
`define DLR_REGS_SVH

// Register offsets (byte addresses on the APB side)
`define DLR_OFS_XCVR_CMD      12'h2a0
`define DLR_OFS_XCVR_RDATA    12'h2a4
`define DLR_OFS_XCVR_LOCK     12'h2a8
`define DLR_OFS_AUDIO_CTRL    12'h300
`define DLR_OFS_INFO_FIRST    12'h304
`define DLR_OFS_INFO_LAST     12'h320
`define DLR_OFS_AUDIO_M       12'h324
`define DLR_OFS_AUDIO_N       12'h328
`define DLR_OFS_AUDIO_STAT    12'h32c
`define DLR_OFS_EXT_FIRST     12'h330
`define DLR_OFS_EXT_LAST      12'h350
`define DLR_OFS_LINK_RATE     12'h400
`define DLR_OFS_LANE_COUNT    12'h404
`define DLR_OFS_FRAMING       12'h408
`define DLR_OFS_TRAIN_PAT     12'h40c

// Command register fields
`define DLR_CMD_ADDR_MSB      7
`define DLR_CMD_WRITE_BIT     15
`define DLR_CMD_WDATA_LSB     16

// Status register fields
`define DLR_STAT_INFO_BIT     0
`define DLR_STAT_RSERR_LSB    1
`define DLR_STAT_EXT_BIT      9

// Packet lengths in words
`define DLR_INFO_WORDS        4'h8
`define DLR_EXT_WORDS         4'h9
`define DLR_TS_WORDS          4'h2

// Auxiliary channel field selects
`define DLR_AUX_RATE          2'h0
`define DLR_AUX_LANES         2'h1
`define DLR_AUX_FRAMING       2'h2
`define DLR_AUX_TRAIN         2'h3

// Link rate codes
`define DLR_RATE_1G62         8'h06
`define DLR_RATE_2G7          8'h0a
`define DLR_RATE_5G4          8'h14

// Suggested software wait after a command, in bus clock periods
`define DLR_CMD_WAIT_CYCLES   10

`endif

//--- design/dlr_pkg.sv
// Types shared by the sink register slice, its link partner and the link
// interface. Offsets and counts live in dlr_regs.svh.
`include "dlr_regs.svh"

package dlr_pkg;

  // Packet kinds carried on the link
  typedef enum logic [2:0] {
    DLR_KIND_INFO = 3'h0,  // Audio infoframe, eight words
    DLR_KIND_TS   = 3'h1,  // Audio timestamp, M then N
    DLR_KIND_ACM  = 3'h2,  // Audio copy management, extension buffer
    DLR_KIND_REC  = 3'h3,  // recording_code_packet, extension buffer
    DLR_KIND_VSC  = 3'h4   // video_stream_config_packet, extension buffer
  } dlr_kind_t;

  // Transceiver configuration sequencer states
  typedef enum logic [2:0] {
    DLR_CFG_IDLE  = 3'b001,
    DLR_CFG_ISSUE = 3'b010,
    DLR_CFG_WAIT  = 3'b100
  } dlr_cfg_st_t;

  // Source-side sequencer states
  typedef enum logic [3:0] {
    DLR_TX_IDLE = 4'b0001,
    DLR_TX_PKT  = 4'b0010,
    DLR_TX_TS   = 4'b0100,
    DLR_TX_AUX  = 4'b1000
  } dlr_tx_st_t;

  // Sink state
  typedef struct packed {
    dlr_cfg_st_t       cfg_st;
    logic [31:0]       cmd;
    logic [15:0]       cfg_rdata;
    logic              audio_en;
    logic [7:0][31:0]  info;
    logic [3:0]        info_wr;
    logic [3:0]        info_rd;
    logic              info_full;
    logic [8:0][31:0]  ext;
    logic [3:0]        ext_wr;
    logic [3:0]        ext_rd;
    logic              ext_full;
    logic [23:0]       m_val;
    logic [23:0]       n_val;
    logic              ts_second;
    logic [1:0]        rs_cnt;
    logic [7:0]        rate;
    logic [4:0]        lanes;
    logic              enh;
    logic [1:0]        tp;
    logic [31:0]       prdata;
    logic              pslverr;
  } dlr_dev_state_t;

  // Source state
  typedef struct packed {
    dlr_tx_st_t        st;
    dlr_kind_t         kind;
    logic [3:0]        cnt;
    logic              hold_valid;
    logic [31:0]       hold;
    logic [23:0]       n_save;
    logic [7:0]        rate;
    logic [4:0]        lanes;
    logic              enh;
    logic [1:0]        tp;
    logic              aux_wr;
    logic [1:0]        aux_field;
    logic [7:0]        aux_data;
    logic              rs_err;
  } dlr_src_state_t;

  // Words in one packet of the given kind
  function automatic logic [3:0] dlr_pkt_len(input dlr_kind_t kind);
    unique case (kind)
      DLR_KIND_INFO: dlr_pkt_len = `DLR_INFO_WORDS;
      DLR_KIND_TS:   dlr_pkt_len = `DLR_TS_WORDS;
      default:       dlr_pkt_len = `DLR_EXT_WORDS;
    endcase
  endfunction

endpackage

//--- design/dlr_link_if.sv
// Link between the remote source controller and the sink register slice.
// Both ends run on the same pclk; the bench connects the interface.
`timescale 1ns/1ps
`default_nettype none

interface dlr_link_if;
  import dlr_pkg::*;
  logic        pkt_valid;  // Source offers a packet word
  dlr_kind_t   pkt_kind;   // Kind of the packet in flight
  logic [31:0] pkt_data;   // Packet word, header word first
  logic        pkt_last;   // Final word of the packet
  logic        pkt_ready;  // Sink takes the word this edge
  logic        aux_wr;     // One-cycle write of a link setting field
  logic [1:0]  aux_field;  // Which field
  logic [7:0]  aux_data;   // New field value
  logic        rs_err;     // One-cycle decoder error report

  modport sink (input pkt_valid, pkt_kind, pkt_data, pkt_last, aux_wr, aux_field, aux_data, rs_err,
                output pkt_ready);
  modport source (output pkt_valid, pkt_kind, pkt_data, pkt_last, aux_wr, aux_field, aux_data, rs_err,
                  input pkt_ready);
endinterface

`default_nettype wire

//--- design/dlr_source.sv
// Remote source controller end: frames packet words onto the link, sends
// timestamps and pushes link setting changes over the auxiliary path.
// Assumes the same pclk as the sink and a user that honours word_ready.
`include "dlr_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module dlr_source (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Link to the sink
  dlr_link_if.source             link,
  // Packet request and word supply
  input  wire logic              pkt_start,
  input  wire dlr_pkg::dlr_kind_t pkt_kind,
  input  wire logic              word_valid,
  input  wire logic [31:0]       word_data,
  output logic                   word_ready,
  output logic                   busy,
  // Timestamp request
  input  wire logic              ts_send,
  input  wire logic [23:0]       ts_m,
  input  wire logic [23:0]       ts_n,
  // Link settings, pushed when they change
  input  wire logic [7:0]        set_rate,
  input  wire logic [4:0]        set_lanes,
  input  wire logic              set_enh,
  input  wire logic [1:0]        set_tp,
  // Decoder error event
  input  wire logic              rs_err_in
);
  import dlr_pkg::*;

  localparam dlr_src_state_t RST = '{st: DLR_TX_IDLE, kind: DLR_KIND_INFO, default: '0};

  dlr_src_state_t cur;    // Registered state
  dlr_src_state_t next_s; // Next state
  logic           sent;   // Held word accepted by the sink
  logic           last;   // Held word ends the packet

  // Link drive; every data output comes from the state register
  assign sent           = cur.hold_valid && link.pkt_ready;
  assign last           = (cur.cnt == dlr_pkt_len(cur.kind) - 4'h1);
  assign link.pkt_valid = cur.hold_valid;
  assign link.pkt_kind  = cur.kind;
  assign link.pkt_data  = cur.hold;
  assign link.pkt_last  = cur.hold_valid && last;
  assign link.aux_wr    = cur.aux_wr;
  assign link.aux_field = cur.aux_field;
  assign link.aux_data  = cur.aux_data;
  assign link.rs_err    = cur.rs_err;
  assign word_ready     = (cur.st == DLR_TX_PKT) && !cur.hold_valid;
  assign busy           = (cur.st != DLR_TX_IDLE);

  // Next-state logic
  always_comb begin
    next_s        = cur;
    next_s.aux_wr = 1'b0;
    next_s.rs_err = rs_err_in;
    unique case (cur.st)
      // Setting changes go before a timestamp or packet; a change made during a packet waits for idle
      DLR_TX_IDLE: begin
        if (set_rate != cur.rate) begin
          next_s.st = DLR_TX_AUX;
          next_s.aux_wr = 1'b1;
          next_s.aux_field = `DLR_AUX_RATE;
          next_s.aux_data = set_rate;
          next_s.rate = set_rate;
        end else if (set_lanes != cur.lanes) begin
          next_s.st = DLR_TX_AUX;
          next_s.aux_wr = 1'b1;
          next_s.aux_field = `DLR_AUX_LANES;
          next_s.aux_data = {3'h0, set_lanes};
          next_s.lanes = set_lanes;
        end else if (set_enh != cur.enh) begin
          next_s.st = DLR_TX_AUX;
          next_s.aux_wr = 1'b1;
          next_s.aux_field = `DLR_AUX_FRAMING;
          next_s.aux_data = {7'h0, set_enh};
          next_s.enh = set_enh;
        end else if (set_tp != cur.tp) begin
          next_s.st = DLR_TX_AUX;
          next_s.aux_wr = 1'b1;
          next_s.aux_field = `DLR_AUX_TRAIN;
          next_s.aux_data = {6'h0, set_tp};
          next_s.tp = set_tp;
        end else if (ts_send) begin
          next_s.st = DLR_TX_TS;
          next_s.kind = DLR_KIND_TS;
          next_s.cnt = 4'h0;
          next_s.hold = {8'h0, ts_m};
          next_s.hold_valid = 1'b1;
          next_s.n_save = ts_n;
        end else if (pkt_start) begin
          next_s.st = DLR_TX_PKT;
          next_s.kind = pkt_kind;
          next_s.cnt = 4'h0;
        end
      end
      // One idle cycle between auxiliary writes
      DLR_TX_AUX: next_s.st = DLR_TX_IDLE;
      // Exactly the fixed word count is sent; half rate trades speed for one register
      DLR_TX_PKT: begin
        if (!cur.hold_valid && word_valid) begin
          next_s.hold = word_data;
          next_s.hold_valid = 1'b1;
        end else if (sent) begin
          next_s.hold_valid = 1'b0;
          next_s.cnt = cur.cnt + 4'h1;
          if (last) begin
            next_s.st = DLR_TX_IDLE;
          end
        end
      end
      // M word, then N word
      DLR_TX_TS: begin
        if (sent) begin
          if (last) begin
            next_s.hold_valid = 1'b0;
            next_s.st = DLR_TX_IDLE;
          end else begin
            next_s.hold = {8'h0, cur.n_save};
            next_s.cnt = cur.cnt + 4'h1;
          end
        end
      end
      default: next_s.st = DLR_TX_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= RST;
    end else begin
      cur <= next_s;
    end
  end

endmodule

`default_nettype wire

//--- tb/dlr_link_assertions.sv
// Checker for the link between the source and sink ends.
// Assumes the bench wires it beside the one link instance.
`include "dlr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module dlr_link_assertions (
  // Clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // Packet path
  input wire logic               pkt_valid,
  input wire dlr_pkg::dlr_kind_t pkt_kind,
  input wire logic [31:0]        pkt_data,
  input wire logic               pkt_last,
  input wire logic               pkt_ready,
  // Side paths
  input wire logic               aux_wr,
  input wire logic [1:0]         aux_field,
  input wire logic [7:0]         aux_data,
  input wire logic               rs_err
);
  import dlr_pkg::*;
  logic [3:0] n_taken;  // Words taken so far in this packet
  logic       take;     // Word handed over at this edge
  assign take = pkt_valid && pkt_ready;
  // Word counter, so a packet's length shows at its last word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) n_taken <= 4'h0;
    else if (take) n_taken <= pkt_last ? 4'h0 : n_taken + 4'h1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_hold; pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_data) && $stable(pkt_last); endproperty
  a_hold: assert property (p_hold) else $error("word changed before taken");
  // Packet words leave a gap after each take; only the timestamp's N word follows its M word at once
  property p_gap; take |=> pkt_valid == (pkt_kind == DLR_KIND_TS && !$past(pkt_last)); endproperty
  a_gap: assert property (p_gap) else $error("word offered right after take");
  property p_ts_ready; pkt_valid && pkt_kind == DLR_KIND_TS |-> pkt_ready; endproperty
  a_ts_ready: assert property (p_ts_ready) else $error("timestamp word held off");
  property p_info_len; take && pkt_kind == DLR_KIND_INFO |-> pkt_last == (n_taken == 4'h7); endproperty
  a_info_len: assert property (p_info_len) else $error("infoframe not eight words");
  property p_ext_len; take && pkt_kind inside {DLR_KIND_ACM, DLR_KIND_REC, DLR_KIND_VSC} |-> pkt_last == (n_taken == 4'h8); endproperty
  a_ext_len: assert property (p_ext_len) else $error("extension not nine words");
  property p_ts_len; take && pkt_kind == DLR_KIND_TS |-> pkt_last == (n_taken == 4'h1); endproperty
  a_ts_len: assert property (p_ts_len) else $error("timestamp not two words");
  property p_rate; aux_wr && aux_field == `DLR_AUX_RATE |-> aux_data inside {8'h06, 8'h0a, 8'h14}; endproperty
  a_rate: assert property (p_rate) else $error("bad link rate code");
  property p_aux; aux_wr |=> !aux_wr; endproperty
  a_aux: assert property (p_aux) else $error("setting write not one cycle");
  property p_rs; rs_err |=> !rs_err; endproperty
  a_rs: assert property (p_rs) else $error("error report not one cycle");
  // Main traffic kinds seen
  c_info: cover property (take && pkt_last && pkt_kind == DLR_KIND_INFO);
  c_ext: cover property (take && pkt_last && pkt_kind == DLR_KIND_VSC);
  c_aux: cover property (aux_wr && aux_field == `DLR_AUX_TRAIN);
endmodule
`default_nettype wire

//--- tb/dp_sink_xcvr_audio_link_regs_test.sv
// Bench joining source and sink ends; drives APB and the source user side.
// Assumes one pclk for every part.
`timescale 1ns/1ps
`default_nettype none
module dp_sink_xcvr_audio_link_regs_test;
  import dlr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata_q, word_data;
  logic xcvr_cfg_en, xcvr_cfg_we, xcvr_cfg_ready, xcvr_cfg_internal_busy;
  logic [7:0] xcvr_cfg_addr, set_rate;
  logic [15:0] xcvr_cfg_wdata, xcvr_cfg_rdata;
  logic pkt_start, word_valid, word_ready, busy, ts_send, set_enh, rs_err_in;
  dlr_kind_t pkt_kind;
  logic [23:0] ts_m, ts_n;
  logic [4:0] set_lanes;
  logic [1:0] set_tp;
  int n_fail = 0, checks_done = 0, cycles = 0;
  dlr_link_if link ();
  dlr_sink u_dlr_sink (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .link(link), .xcvr_cfg_en, .xcvr_cfg_we, .xcvr_cfg_addr, .xcvr_cfg_wdata, .xcvr_cfg_ready, .xcvr_cfg_rdata,
    .xcvr_cfg_internal_busy);
  dlr_source u_dlr_source (.pclk, .presetn, .link(link), .pkt_start, .pkt_kind, .word_valid, .word_data,
    .word_ready, .busy, .ts_send, .ts_m, .ts_n, .set_rate, .set_lanes, .set_enh, .set_tp, .rs_err_in);
  dlr_link_assertions u_dlr_link_assertions (.pclk, .presetn, .pkt_valid(link.pkt_valid),
    .pkt_kind(link.pkt_kind), .pkt_data(link.pkt_data), .pkt_last(link.pkt_last), .pkt_ready(link.pkt_ready),
    .aux_wr(link.aux_wr), .aux_field(link.aux_field), .aux_data(link.aux_data), .rs_err(link.rs_err));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Hang guard: far above the length of all tests
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // APB transfer; waits on pready, takes data at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata_q, e);
  endtask
  // Settling time covers several setting writes with gaps between them
  task automatic idle();
    repeat (10) @(posedge pclk);
    while (busy) @(posedge pclk);
  endtask
  task automatic send(input dlr_kind_t k, input int n, input logic [31:0] base);
    @(posedge pclk);
    pkt_start <= 1'b1;
    pkt_kind <= k;
    word_valid <= 1'b1;
    word_data <= base;
    @(posedge pclk);
    pkt_start <= 1'b0;
    for (int i = 1; i <= n; i++) begin
      @(negedge pclk);
      while (!word_ready) @(negedge pclk);
      @(posedge pclk);
      word_data <= base + i;
    end
    word_valid <= 1'b0;
    idle();
  endtask
  task automatic ts(input logic [23:0] m, input logic [23:0] n);
    @(posedge pclk);
    ts_send <= 1'b1;
    ts_m <= m;
    ts_n <= n;
    @(posedge pclk);
    ts_send <= 1'b0;
    idle();
  endtask
  // One command: port strobe next cycle, then a ready answer
  task automatic issue(input logic [31:0] d, input logic [15:0] rd);
    rdchk(12'h2a8, 32'h0);
    apb(1'b1, 12'h2a0, d);
    @(negedge pclk);
    chk({xcvr_cfg_en, xcvr_cfg_we, xcvr_cfg_addr, xcvr_cfg_wdata}, {1'b1, d[15], d[7:0], d[31:16]});
    @(posedge pclk);
    xcvr_cfg_ready <= 1'b1;
    xcvr_cfg_rdata <= rd;
    @(posedge pclk);
    xcvr_cfg_ready <= 1'b0;
    repeat (10) @(posedge pclk);
  endtask
  task automatic t_mirror();
    logic [7:0] codes [3] = '{8'h06, 8'h0a, 8'h14};
    for (int i = 0; i < 3; i++) begin
      set_rate <= codes[i];
      idle();
      rdchk(12'h400, {24'h0, codes[i]});
    end
    set_lanes <= 5'h4;
    set_enh <= 1'b1;
    set_tp <= 2'h1;
    idle();
    rdchk(12'h404, 32'h4);
    rdchk(12'h408, 32'h1);
    rdchk(12'h40c, 32'h1);
    set_tp <= 2'h2;
    idle();
    rdchk(12'h40c, 32'h2);
    apb(1'b1, 12'h400, 32'hff);
    rdchk(12'h400, 32'h14);
    $display("test mirror done");
  endtask
  task automatic t_xcvr();
    issue(32'hbeef805a, 16'h0bad);
    issue(32'h00000033, 16'hc0de);
    rdchk(12'h2a4, 32'h0000c0de);
    xcvr_cfg_internal_busy <= 1'b1;
    rdchk(12'h2a8, 32'h1);
    apb(1'b1, 12'h2a0, 32'h00000044);
    @(negedge pclk);
    chk(xcvr_cfg_en, 1'b0);
    rdchk(12'h2a0, 32'h00000044);
    xcvr_cfg_internal_busy <= 1'b0;
    rdchk(12'h2a8, 32'h0);
    apb(1'b0, 12'h500, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    chk(rdata_q, 32'h0);
    $display("test xcvr done");
  endtask
  task automatic t_audio();
    ts(24'h111111, 24'h222222);
    rdchk(12'h324, 32'h0);
    apb(1'b1, 12'h300, 32'h1);
    rdchk(12'h300, 32'h1);
    ts(24'habcdef, 24'h123456);
    rdchk(12'h324, 32'h00abcdef);
    rdchk(12'h328, 32'h00123456);
    send(DLR_KIND_INFO, 8, 32'h03020100);
    rdchk(12'h32c, 32'h1);
    for (int i = 0; i < 8; i++) rdchk(12'h304 + 12'(4 * i), 32'h03020100 + i);
    rdchk(12'h32c, 32'h0);
    for (int k = 0; k < 3; k++) begin
      send(dlr_kind_t'(3'h2 + 3'(k)), 9, 32'hc0000000 + (k << 8));
      rdchk(12'h32c, 32'h200);
      for (int i = 0; i < 9; i++) rdchk(12'h330 + 12'(4 * i), 32'hc0000000 + (k << 8) + i);
      rdchk(12'h32c, 32'h0);
    end
    repeat (4) begin
      @(posedge pclk);
      rs_err_in <= 1'b1;
      @(posedge pclk);
      rs_err_in <= 1'b0;
    end
    repeat (3) @(posedge pclk);
    rdchk(12'h32c, 32'h6);
    $display("test audio done");
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, xcvr_cfg_ready, xcvr_cfg_rdata, xcvr_cfg_internal_busy} = '0;
    {pkt_start, word_valid, word_data, ts_send, ts_m, ts_n, set_rate, set_lanes, set_enh, set_tp, rs_err_in} = '0;
    pkt_kind = DLR_KIND_INFO;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_mirror();
    t_xcvr();
    t_audio();
    complete_run();
  end
endmodule
`default_nettype wire
